// >>> core/kpi_defs.vh
// Purpose: constants for the keyboard pin interrupt block
// Assumes: 8-bit registers on a simple strobe port
// Notes: offsets are register indices on the local port
`ifndef KPI_DEFS_VH
`define KPI_DEFS_VH
`define KPI_ADDR_W 2
`define KPI_OFF_STATUS_CONTROL 2'h0
`define KPI_OFF_PIN_ENABLE 2'h1
`define KPI_OFF_POLARITY_SELECT 2'h2
`define KPI_BIT_EVENT_FLAG 3
`define KPI_BIT_EVENT_ACK 2
`define KPI_BIT_IRQ_ENABLE 1
`define KPI_BIT_DETECT_MODE 0
`define KPI_RST_STATUS_CONTROL 8'h00
`define KPI_RST_PIN_ENABLE 8'h00
`define KPI_RST_POLARITY_SELECT 8'h00
`define KPI_PINS 8
`endif

// >>> core/kpi_pin_detect.v
// Purpose: per-pin asserted level and edge detection
// Assumes: inputs synchronous to mclk
// Notes: one sample register per pin
module kpi_pin_detect
(
    input wire mclk, // clock
    input wire nrst, // async reset, active low
    input wire [7:0] key_input_pins, // raw key inputs
    input wire [7:0] pin_enable_bits, // pin enables
    input wire [7:0] pin_polarity_bits, // 0 falling/low, 1 rising/high
    output wire [7:0] pin_asserted, // enabled pin at asserted level
    output wire [7:0] pin_edge // enabled pin went deasserted to asserted
);
    reg [7:0] prev_asserted;
    wire [7:0] now_asserted;

    // =========================================================
    // polarity and enable
    genvar i;
    generate
        for (i = 0; i < 8; i = i + 1)
        begin : g_pin
            // polarity 0 asserts low, 1 asserts high
            assign now_asserted[i] = key_input_pins[i] ~^ pin_polarity_bits[i];
            assign pin_asserted[i] = now_asserted[i] & pin_enable_bits[i];
            // deasserted one bus cycle, asserted the next
            assign pin_edge[i] = pin_asserted[i] & ~prev_asserted[i];
        end
    endgenerate

    // =========================================================
    // previous sample
    always @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            prev_asserted <= 8'h00;
        else
            prev_asserted <= pin_asserted;
    end
endmodule // kpi_pin_detect

// >>> core/kpi_top.v
// Purpose: keyboard pin interrupt block with three 8-bit registers
// Assumes: register port strobes one cycle; pins synchronous to mclk
// Notes: read data valid the cycle after the read strobe
//
// What this block does
// - status bits 7:4 read zero
// - flag bit 3 read-only
// - bit 2 write-one acknowledge, reads zero
// - bit 1 gates interrupt request
// - bit 0 selects edge or edge+level
// - pin enable bit includes each pin
// - polarity bit selects falling/low or rising/high
// - falling edge: high then low sample
// - rising edge: low then high sample
// - no new edge until all deasserted
// - edge mode: edge sets flag, requests interrupt
// - edge mode: acknowledge clears flag
// - level mode: edge or level sets flag
// - level mode: acknowledge fails while asserted
// - polarity picks pullup or pulldown
// - eight independently enabled input pins
// - stop-state wake via asynchronous detection
//
// Local design decisions: the address-and-strobe port and the address map.
`include "kpi_defs.vh"
module kpi_top
(
    input wire mclk, // 200 MHz clock
    input wire nrst, // async reset, active low
    input wire [1:0] reg_addr, // register index
    input wire [7:0] reg_wdata, // write data
    input wire reg_wr, // write strobe
    input wire reg_rd, // read strobe
    output reg [7:0] reg_rdata, // read data, cycle after strobe
    input wire [7:0] key_input_pins, // key inputs
    input wire [7:0] port_pullup_enable, // resistor enables from port
    output wire [7:0] pull_up_en, // enable pullup per pin
    output wire [7:0] pull_down_en, // enable pulldown per pin
    output wire wake_request, // wake request in stop state
    output reg irq // interrupt request
);
    reg event_flag;
    reg interrupt_enable_bit;
    reg detect_mode_select;
    reg [7:0] pin_enable_bits;
    reg [7:0] pin_polarity_bits;
    reg armed;
    wire [7:0] pin_asserted;
    wire [7:0] pin_edge;
    wire any_asserted;
    wire edge_seen;
    wire level_seen;
    wire set_event;
    wire ack_write;
    wire wr_sc;
    wire [7:0] status_view;
    // status reset value kept whole so single bits can be picked out
    localparam [7:0] sc_reset = `KPI_RST_STATUS_CONTROL;

    // =========================================================
    // pin detection
    kpi_pin_detect u_detect
    (
        .mclk(mclk),
        .nrst(nrst),
        .key_input_pins(key_input_pins),
        .pin_enable_bits(pin_enable_bits),
        .pin_polarity_bits(pin_polarity_bits),
        .pin_asserted(pin_asserted),
        .pin_edge(pin_edge)
    );

    assign any_asserted = |pin_asserted;
    assign edge_seen = armed & (|pin_edge);
    assign level_seen = detect_mode_select & any_asserted;
    assign set_event = edge_seen | level_seen;

    // =========================================================
    // edge re-arm: disarm on edge, re-arm once all deasserted
    always @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            armed <= 1'b1;
        else if (!any_asserted)
            armed <= 1'b1;
        else if (|pin_edge)
            armed <= 1'b0;
    end

    // =========================================================
    // register writes
    assign wr_sc = reg_wr & (reg_addr == `KPI_OFF_STATUS_CONTROL);
    assign ack_write = wr_sc & reg_wdata[`KPI_BIT_EVENT_ACK];

    always @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            interrupt_enable_bit <= sc_reset[`KPI_BIT_IRQ_ENABLE];
            detect_mode_select <= sc_reset[`KPI_BIT_DETECT_MODE];
            pin_enable_bits <= `KPI_RST_PIN_ENABLE;
            pin_polarity_bits <= `KPI_RST_POLARITY_SELECT;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                `KPI_OFF_STATUS_CONTROL:
                begin
                    interrupt_enable_bit <= reg_wdata[`KPI_BIT_IRQ_ENABLE];
                    detect_mode_select <= reg_wdata[`KPI_BIT_DETECT_MODE];
                end
                `KPI_OFF_PIN_ENABLE: pin_enable_bits <= reg_wdata;
                `KPI_OFF_POLARITY_SELECT: pin_polarity_bits <= reg_wdata;
                default:
                begin
                    pin_enable_bits <= pin_enable_bits;
                end
            endcase
        end
    end

    // =========================================================
    // event flag: set wins over acknowledge
    always @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            event_flag <= 1'b0;
        else if (set_event)
            event_flag <= 1'b1;
        else if (ack_write)
            event_flag <= 1'b0;
    end

    // =========================================================
    // interrupt request
    always @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            irq <= 1'b0;
        else
            irq <= event_flag & interrupt_enable_bit;
    end

    // asynchronous path for the stop state, no clock needed
    assign wake_request = interrupt_enable_bit & any_asserted;

    // =========================================================
    // resistor direction
    assign pull_up_en = port_pullup_enable & ~pin_polarity_bits;
    assign pull_down_en = port_pullup_enable & pin_polarity_bits;

    // =========================================================
    // register reads
    assign status_view = {4'h0, event_flag, 1'b0, interrupt_enable_bit,
        detect_mode_select};

    always @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            reg_rdata <= 8'h00;
        else if (reg_rd)
        begin
            case (reg_addr)
                `KPI_OFF_STATUS_CONTROL: reg_rdata <= status_view;
                `KPI_OFF_PIN_ENABLE: reg_rdata <= pin_enable_bits;
                `KPI_OFF_POLARITY_SELECT: reg_rdata <= pin_polarity_bits;
                default: reg_rdata <= 8'h00;
            endcase
        end
        else
            reg_rdata <= 8'h00;
    end
endmodule // kpi_top

// >>> verif/kpi_assertions.sv
// Purpose: port checks for the keyboard pin interrupt block
// Assumes: one clock, async active-low reset
// Notes: bound to kpi_top from the bench top file
module kpi_assertions
(
    input wire mclk, // clock
    input wire nrst, // reset, active low
    input wire [1:0] reg_addr, // register index
    input wire [7:0] reg_wdata, // write data
    input wire reg_wr, // write strobe
    input wire reg_rd, // read strobe
    input wire [7:0] reg_rdata, // read data
    input wire [7:0] key_input_pins, // key inputs
    input wire [7:0] port_pullup_enable, // resistor enables
    input wire [7:0] pull_up_en, // pullup out
    input wire [7:0] pull_down_en, // pulldown out
    input wire wake_request, // wake out
    input wire irq // request out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    // ==========================================
    // register port, resistors and request
    a_status_upper:
    assert property (reg_rd && reg_addr == 2'h0 |=> reg_rdata[7:4] == 4'h0) else $error("upper");
    a_ack_zero:
    assert property (reg_rd && reg_addr == 2'h0 |=> !reg_rdata[2]) else $error("ack bit set");
    a_unmapped_zero:
    assert property (reg_rd && reg_addr == 2'h3 |=> reg_rdata == 8'h00) else $error("unmapped");
    a_pull_cover:
    assert property ((pull_up_en | pull_down_en) == port_pullup_enable) else $error("pull");
    a_pull_excl:
    assert property ((pull_up_en & pull_down_en) == 8'h00) else $error("pull both");
    a_mask_irq:
    assert property (reg_wr && reg_addr == 2'h0 && !reg_wdata[1] |=> ##1 !irq) else $error("mask");
    a_irq_follows:
    assert property (reg_rd && reg_addr == 2'h0 |=> irq == (reg_rdata[3] & reg_rdata[1]))
        else $error("irq");
    a_wake_gated:
    assert property (wake_request && reg_rd && reg_addr == 2'h0 |=> reg_rdata[1]) else $error("wake");
    c_irq: cover property ($rose(irq));
    c_wake: cover property (wake_request);
    c_ack: cover property (reg_wr && reg_wdata[2]);
endmodule // kpi_assertions

// >>> verif/kpi_keys.sv
// Purpose: key switch model for the keypad pins
// Assumes: a pressed key drives the level opposite its resistor
// Notes: a pin with no resistor and no key flips each cycle
module kpi_keys
(
    input wire mclk, // clock
    input wire [7:0] press, // keys held
    input wire [7:0] pull_up_en, // pullup on
    input wire [7:0] pull_down_en, // pulldown on
    output logic [7:0] pins // pin levels
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] last = 8'h00;
    always @(posedge mclk) last <= pins;
    // idle keys with a resistor rest at the deasserted level
    assign pins = (press & pull_down_en)
        | (~press & (pull_up_en | (~pull_down_en & ~last)));
endmodule // kpi_keys

// >>> verif/keyboard_pin_interrupt_bench.sv
// Purpose: self-checking bench for the keyboard pin interrupt block
// Assumes: 200 MHz clock, reset held 20 cycles
// Notes: keys come from the switch model
module keyboard_pin_interrupt_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic [1:0] reg_addr = 2'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] press = 8'h00;
    logic [7:0] port_pullup_enable = 8'hFF;
    wire [7:0] reg_rdata, key_input_pins, pull_up_en, pull_down_en;
    wire wake_request, irq;
    int fails = 0;
    int n_checks = 0;
    always #2.5 mclk = ~mclk;
    kpi_top dut (.mclk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .key_input_pins, .port_pullup_enable, .pull_up_en, .pull_down_en, .wake_request, .irq);
    kpi_keys keys (.mclk, .press, .pull_up_en, .pull_down_en, .pins(key_input_pins));
    task check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [1:0] a, input logic [7:0] e);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 check(reg_rdata, e);
    endtask
    task key(input logic [7:0] k, input logic [7:0] e);
        @(posedge mclk);
        press <= k;
        repeat (3) @(posedge mclk);
        #1 check({7'h0, irq}, e);
    endtask
    task t_regs();
        rd(2'h1, 8'h00);
        wr(2'h1, 8'hA5);
        rd(2'h1, 8'hA5);
        wr(2'h2, 8'h5A);
        rd(2'h2, 8'h5A);
        check(pull_down_en, 8'h5A);
        check(pull_up_en, 8'hA5);
        wr(2'h3, 8'hFF);
        rd(2'h3, 8'h00);
        wr(2'h1, 8'h00);
        // resistors off on the upper pins; those pins are disabled here
        @(posedge mclk);
        port_pullup_enable <= 8'h0F;
        #1 check(pull_up_en, 8'h05);
        check(pull_down_en, 8'h0A);
        @(posedge mclk);
        port_pullup_enable <= 8'hFF;
        wr(2'h0, 8'hFF);
        rd(2'h0, 8'h03);
    endtask
    task t_edge();
        wr(2'h0, 8'h00);
        wr(2'h2, 8'h20);
        wr(2'h1, 8'h28);
        wr(2'h0, 8'h04);
        wr(2'h0, 8'h02);
        key(8'h01, 8'h00);
        key(8'h09, 8'h01);
        check({7'h0, wake_request}, 8'h01);
        rd(2'h0, 8'h0A);
        wr(2'h0, 8'h06);
        key(8'h09, 8'h00);
        key(8'h29, 8'h00);
        key(8'h00, 8'h00);
        key(8'h20, 8'h01);
        wr(2'h0, 8'h06);
        key(8'h00, 8'h00);
    endtask
    task t_level();
        wr(2'h0, 8'h03);
        key(8'h08, 8'h01);
        wr(2'h0, 8'h07);
        rd(2'h0, 8'h0B);
        key(8'h00, 8'h01);
        wr(2'h0, 8'h07);
        rd(2'h0, 8'h03);
        check({7'h0, irq}, 8'h00);
        key(8'h08, 8'h01);
        wr(2'h0, 8'h05);
        key(8'h08, 8'h00);
    endtask
    // reset in mid-run with the flag set and a pulldown selected
    task t_reset();
        @(posedge mclk);
        press <= 8'h00;
        nrst <= 1'b0;
        #1 check(pull_down_en, 8'h00);
        check({7'h0, irq}, 8'h00);
        @(posedge mclk);
        nrst <= 1'b1;
        rd(2'h0, 8'h00);
        rd(2'h1, 8'h00);
        rd(2'h2, 8'h00);
    endtask
    task give_verdict();
        $display("checks=%0d fails=%0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        repeat (20) @(posedge mclk);
        nrst <= 1'b1;
        t_regs();
        t_edge();
        t_level();
        t_reset();
        give_verdict();
    end
    initial
    begin
        #100000;
        fails++;
        give_verdict();
    end
endmodule // keyboard_pin_interrupt_bench
bind kpi_top kpi_assertions chk (.mclk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .key_input_pins, .port_pullup_enable, .pull_up_en, .pull_down_en,
    .wake_request, .irq);
